// File: core/clk_tree_pkg.sv
// Shared constants and types for the system clock tree control block
package clk_tree_pkg;

  // ****************************************************************
  // Core clock sources
  // ****************************************************************
  typedef enum logic [1:0] {
    SRC_XTAL = 2'h0,
    SRC_PLL = 2'h1,
    SRC_OSC = 2'h2,
    SRC_APLL = 2'h3
  } core_src_type;

  // ****************************************************************
  // Synchronised pin vector positions (0..3 follow core_src_type)
  // ****************************************************************
  localparam int PIN_XTAL = 0;
  localparam int PIN_PLL = 1;
  localparam int PIN_OSC = 2;
  localparam int PIN_APLL = 3;
  localparam int PIN_RC150K = 4;
  localparam int PIN_X32K = 5;
  localparam int PIN_SLEEP = 6;
  localparam int PIN_LOWPWR = 7;
  localparam int NUM_PINS = 8;

  // ****************************************************************
  // Register map (word indices) and reset values
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int NUM_REGS = 9;
  localparam logic [3:0] IDX_CLK_SEL = 4'h0;
  localparam logic [3:0] IDX_PREDIV = 4'h1;
  localparam logic [3:0] IDX_TICK_PLL = 4'h2;
  localparam logic [3:0] IDX_TICK_XTAL = 4'h3;
  localparam logic [3:0] IDX_TICK_APLL = 4'h4;
  localparam logic [3:0] IDX_TICK_OSC = 4'h5;
  localparam logic [3:0] IDX_APLL_CFG = 4'h6;
  localparam logic [3:0] IDX_APLL_CTRL = 4'h7;
  localparam logic [3:0] IDX_SENS_DIV = 4'h8;
  localparam logic [3:0] IDX_STATUS = 4'h9;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] REG_MASK [NUM_REGS] = '{
    32'h0000_01FF, 32'h0000_03FF, 32'h0000_00FF, 32'h0000_00FF,
    32'h0000_00FF, 32'h0000_00FF, 32'h1F3F_FFFF, 32'h0000_0003,
    32'h0000_00FF};

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int F_CORE_SRC = 0;
  localparam int F_CORE_PER = 2;
  localparam int F_LED_SEL = 3;
  localparam int F_RADIO_SEL = 4;
  localparam int F_PMGMT_SEL = 6;
  localparam int F_SENS_SEL = 8;
  localparam int F_FRAC_LO = 0;
  localparam int F_FRAC_HI = 8;
  localparam int F_INT = 16;
  localparam int F_OUT_DIV = 24;
  localparam int F_FORCE_ON = 0;
  localparam int F_FORCE_OFF = 1;

  // ****************************************************************
  // Fixed rates and dividers
  // ****************************************************************
  localparam int MAIN_PLL_MHZ = 320;
  localparam logic [7:0] CORE_MHZ_PLL_LO = 8'(MAIN_PLL_MHZ / 4);
  localparam logic [7:0] CORE_MHZ_PLL_HI = 8'(MAIN_PLL_MHZ / 2);
  localparam logic [9:0] PLL_DIV4_M1 = 10'h003;
  localparam logic [9:0] PLL_DIV2_M1 = 10'h001;
  localparam logic [6:0] APLL_INT_OFFSET = 7'h04;
  localparam logic [6:0] APLL_ODIV_OFFSET = 7'h02;
  localparam logic [7:0] OSC_D256_M1 = 8'hFF;
  localparam logic [7:0] HALF_RATE_M1 = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: core/edge_divider.sv
// Toggle-counting clock divider: output toggles every div_i+1 edges
`timescale 1ns/1ps
module edge_divider
  import clk_tree_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic edge_i,
  input wire logic [W-1:0] div_i,
  output logic clk_o
);

  logic [W-1:0] cnt_ff;
  logic clk_ff;

  // Compare with >= so a smaller divisor never strands the count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
      clk_ff <= 1'b0;
    end else if (edge_i) begin
      if (cnt_ff >= div_i) begin
        cnt_ff <= '0;
        clk_ff <= ~clk_ff;
      end else begin
        cnt_ff <= cnt_ff + W'(1);
      end
    end
  end

  assign clk_o = clk_ff;

endmodule

// File: core/soc_clock_tree_control.sv
// System clock tree control: source muxes, dividers and register slave
//
// Notes on behaviour
// - Core source 0 crystal,1 PLL,2 osc,3 audio
// - Crystal or osc core divided by prediv plus one
// - PLL core is /4 or /2 by period
// - Audio PLL core is /4 or /2 by period
// - Bus clock PLL/4, audio core/2, else core
// - Reference tick divisor chosen by active core source
// - LED slow clock: 1 osc, 0 bus clock
// - PLL half clock at half PLL rate
// - Oscillator divided by 256 output
// - LED clock on osc keeps running while bus stopped
// - Radio sleep clock from four selectable sources
// - Power management clock from three sources
// - Sensor clock from divided crystal or osc
// - Audio PLL multiplier and output divider terms
// - Force off beats force on, else follow sleep
// - Main PLL treated as fixed 320 MHz
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module soc_clock_tree_control
  import clk_tree_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic XTAL_CLK_I,
  input wire logic PLL_CLK_I,
  input wire logic OSC8M_CLK_I,
  input wire logic AUDIO_PLL_CLOCK_I,
  input wire logic OSC150K_CLK_I,
  input wire logic XTAL32K_CLK_I,
  input wire logic SLEEP_I,
  input wire logic LOW_POWER_I,
  output logic CORE_CLK_O,
  output logic BUS_CLK_O,
  output logic REF_TICK_O,
  output logic LED_SLOW_CLK_O,
  output logic PLL_HALF_CLK_O,
  output logic OSC_DIV256_O,
  output logic RADIO_SLEEP_CLK_O,
  output logic POWER_MGMT_CLK_O,
  output logic SENSOR_CLK_O,
  output logic RADIO_CLK_OK_O,
  output logic APLL_PU_O,
  output logic [22:0] APLL_MULT_O,
  output logic [6:0] APLL_ODIV_O
);

  // ****************************************************************
  // Decoding functions
  // ****************************************************************
  function automatic logic [9:0] core_div_m1(input core_src_type src,
                                             input logic per,
                                             input logic [9:0] pre);
    case (src)
      SRC_PLL, SRC_APLL: core_div_m1 = per ? PLL_DIV2_M1 : PLL_DIV4_M1;
      default: core_div_m1 = pre;
    endcase
  endfunction

  function automatic logic bus_div_m1(input core_src_type src,
                                      input logic per);
    case (src)
      SRC_PLL: bus_div_m1 = per;
      SRC_APLL: bus_div_m1 = 1'b1;
      default: bus_div_m1 = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    merge = res;
  endfunction

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [NUM_PINS-1:0] sync1_ff;
  logic [NUM_PINS-1:0] sync2_ff;
  logic [NUM_PINS-1:0] prev_ff;
  logic [NUM_PINS-1:0] tgl;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= {LOW_POWER_I, SLEEP_I, XTAL32K_CLK_I, OSC150K_CLK_I,
                   AUDIO_PLL_CLOCK_I, OSC8M_CLK_I, PLL_CLK_I, XTAL_CLK_I};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  assign tgl = sync2_ff ^ prev_ff;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [31:0] regs_ff [NUM_REGS];
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [31:0] status;

  assign wr_idx = AWADDR_I[5:2];
  assign rd_idx = ARADDR_I[5:2];

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= REG_RESET;
      end
    end else if (awready_ff) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (wr_idx == 4'(i) && AWADDR_I[ADDR_W-1:6] == '0) begin
          regs_ff[i] <= merge(regs_ff[i], WDATA_I, WSTRB_I) & REG_MASK[i];
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      awready_ff <= AWVALID_I && WVALID_I && !awready_ff && !bvalid_ff;
      wready_ff <= AWVALID_I && WVALID_I && !awready_ff && !bvalid_ff;
      if (awready_ff) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (AWADDR_I[ADDR_W-1:6] == '0 &&
                     wr_idx < 4'(NUM_REGS)) ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY_I) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= ARVALID_I && !arready_ff && !rvalid_ff;
      if (arready_ff) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= '0;
        rresp_ff <= RESP_SLVERR;
        if (ARADDR_I[ADDR_W-1:6] == '0) begin
          if (rd_idx < 4'(NUM_REGS)) begin
            rdata_ff <= regs_ff[rd_idx];
            rresp_ff <= RESP_OKAY;
          end else if (rd_idx == IDX_STATUS) begin
            rdata_ff <= status;
            rresp_ff <= RESP_OKAY;
          end
        end
      end else if (RREADY_I) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Configuration fields
  // ****************************************************************
  core_src_type pend_src;
  logic pend_per;
  logic [9:0] pend_pre;
  logic led_sel;
  logic [1:0] radio_sel;
  logic [1:0] pmgmt_sel;
  logic sens_sel;

  assign pend_src = core_src_type'(regs_ff[IDX_CLK_SEL][F_CORE_SRC +: 2]);
  assign pend_per = regs_ff[IDX_CLK_SEL][F_CORE_PER];
  assign pend_pre = regs_ff[IDX_PREDIV][9:0];
  assign led_sel = regs_ff[IDX_CLK_SEL][F_LED_SEL];
  assign radio_sel = regs_ff[IDX_CLK_SEL][F_RADIO_SEL +: 2];
  assign pmgmt_sel = regs_ff[IDX_CLK_SEL][F_PMGMT_SEL +: 2];
  assign sens_sel = regs_ff[IDX_CLK_SEL][F_SENS_SEL];

  // ****************************************************************
  // Core clock: source mux and divider
  // ****************************************************************
  core_src_type act_src_ff;
  logic act_per_ff;
  logic [9:0] act_pre_ff;
  logic [9:0] core_cnt_ff;
  logic core_clk_ff;
  logic core_tgl_ff;
  logic core_edge;
  logic [9:0] core_m1;

  assign core_edge = tgl[act_src_ff];
  assign core_m1 = core_div_m1(act_src_ff, act_per_ff, act_pre_ff);

  // New settings only take effect while the output is low
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      act_src_ff <= SRC_XTAL;
      act_per_ff <= 1'b0;
      act_pre_ff <= '0;
      core_cnt_ff <= '0;
      core_clk_ff <= 1'b0;
      core_tgl_ff <= 1'b0;
    end else begin
      core_tgl_ff <= 1'b0;
      if (!core_clk_ff && {act_src_ff, act_per_ff, act_pre_ff} !=
          {pend_src, pend_per, pend_pre}) begin
        act_src_ff <= pend_src;
        act_per_ff <= pend_per;
        act_pre_ff <= pend_pre;
        core_cnt_ff <= '0;
      end else if (core_edge) begin
        if (core_cnt_ff >= core_m1) begin
          core_cnt_ff <= '0;
          core_clk_ff <= ~core_clk_ff;
          core_tgl_ff <= 1'b1;
        end else begin
          core_cnt_ff <= core_cnt_ff + 10'h001;
        end
      end
    end
  end

  // ****************************************************************
  // Bus clock and reference tick
  // ****************************************************************
  logic bus_m1_ff;
  logic bus_cnt_ff;
  logic bus_clk_ff;
  logic bus_rise_ff;
  logic bus_want;
  logic low_power;
  logic [7:0] tick_cnt_ff;
  logic tick_ff;
  logic [7:0] tick_div;

  assign bus_want = bus_div_m1(act_src_ff, act_per_ff);
  assign low_power = sync2_ff[PIN_LOWPWR];

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bus_m1_ff <= 1'b0;
      bus_cnt_ff <= 1'b0;
      bus_clk_ff <= 1'b0;
      bus_rise_ff <= 1'b0;
    end else begin
      bus_rise_ff <= 1'b0;
      if (!bus_clk_ff && (low_power || bus_m1_ff != bus_want)) begin
        bus_m1_ff <= bus_want;
        bus_cnt_ff <= 1'b0;
      end else if (core_tgl_ff) begin
        if (bus_cnt_ff >= bus_m1_ff) begin
          bus_cnt_ff <= 1'b0;
          bus_clk_ff <= ~bus_clk_ff;
          bus_rise_ff <= ~bus_clk_ff;
        end else begin
          bus_cnt_ff <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    case (act_src_ff)
      SRC_PLL: tick_div = regs_ff[IDX_TICK_PLL][7:0];
      SRC_APLL: tick_div = regs_ff[IDX_TICK_APLL][7:0];
      SRC_OSC: tick_div = regs_ff[IDX_TICK_OSC][7:0];
      default: tick_div = regs_ff[IDX_TICK_XTAL][7:0];
    endcase
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (bus_rise_ff) begin
        if (tick_cnt_ff >= tick_div) begin
          tick_cnt_ff <= '0;
          tick_ff <= 1'b1;
        end else begin
          tick_cnt_ff <= tick_cnt_ff + 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Fixed dividers and the programmable sensor divider
  // ****************************************************************
  logic pll_half;
  logic osc_d256;
  logic sens_xtal;

  edge_divider #(.W(8)) u_pll_half (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .edge_i(tgl[PIN_PLL]),
    .div_i(HALF_RATE_M1),
    .clk_o(pll_half)
  );

  edge_divider #(.W(8)) u_osc_d256 (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .edge_i(tgl[PIN_OSC]),
    .div_i(OSC_D256_M1),
    .clk_o(osc_d256)
  );

  edge_divider #(.W(8)) u_sens_div (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .edge_i(tgl[PIN_XTAL]),
    .div_i(regs_ff[IDX_SENS_DIV][7:0]),
    .clk_o(sens_xtal)
  );

  // ****************************************************************
  // Slow clock muxes: LED, radio sleep, power management, sensor
  // ****************************************************************
  logic [3:0] cand [4];
  logic [1:0] msel [4];
  logic [1:0] mact_ff [4];
  logic [3:0] mux_ff;

  assign cand[0] = {2'b00, sync2_ff[PIN_OSC], bus_clk_ff};
  assign cand[1] = {sync2_ff[PIN_XTAL], sync2_ff[PIN_OSC], mux_ff[2],
                    sync2_ff[PIN_RC150K]};
  assign cand[2] = {sync2_ff[PIN_RC150K], osc_d256, sync2_ff[PIN_X32K],
                    sync2_ff[PIN_RC150K]};
  assign cand[3] = {2'b00, sync2_ff[PIN_OSC], sens_xtal};
  assign msel[0] = {1'b0, led_sel};
  assign msel[1] = radio_sel;
  assign msel[2] = pmgmt_sel;
  assign msel[3] = {1'b0, sens_sel};

  generate
    for (genvar m = 0; m < 4; m++) begin : g_mux
      always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          mact_ff[m] <= 2'h0;
          mux_ff[m] <= 1'b0;
        end else if (!mux_ff[m] && mact_ff[m] != msel[m]) begin
          mact_ff[m] <= msel[m];
        end else begin
          mux_ff[m] <= cand[m][mact_ff[m]];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Audio PLL control and status
  // ****************************************************************
  logic apll_pu_ff;
  logic radio_ok_ff;
  logic [22:0] apll_mult_ff;
  logic [6:0] apll_odiv_ff;
  logic [31:0] cfg;
  logic [1:0] force_bits;

  assign cfg = regs_ff[IDX_APLL_CFG];
  assign force_bits = regs_ff[IDX_APLL_CTRL][1:0];

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      apll_pu_ff <= 1'b0;
      radio_ok_ff <= 1'b0;
      apll_mult_ff <= '0;
      apll_odiv_ff <= '0;
    end else begin
      if (force_bits[F_FORCE_OFF]) begin
        apll_pu_ff <= 1'b0;
      end else if (force_bits[F_FORCE_ON]) begin
        apll_pu_ff <= 1'b1;
      end else begin
        apll_pu_ff <= ~sync2_ff[PIN_SLEEP];
      end
      radio_ok_ff <= act_src_ff == SRC_PLL && !low_power;
      apll_mult_ff <= {7'(cfg[F_INT +: 6]) + APLL_INT_OFFSET,
                       cfg[F_FRAC_HI +: 8], cfg[F_FRAC_LO +: 8]};
      apll_odiv_ff <= 7'((7'(cfg[F_OUT_DIV +: 5]) + APLL_ODIV_OFFSET)
                         << 1);
    end
  end

  always_comb begin
    status = '0;
    status[1:0] = act_src_ff;
    status[2] = act_per_ff;
    status[3] = ~low_power;
    status[4] = apll_pu_ff;
    status[5] = radio_ok_ff;
    if (act_src_ff == SRC_PLL) begin
      status[15:8] = act_per_ff ? CORE_MHZ_PLL_HI : CORE_MHZ_PLL_LO;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign AWREADY_O = awready_ff;
  assign WREADY_O = wready_ff;
  assign BVALID_O = bvalid_ff;
  assign BRESP_O = bresp_ff;
  assign ARREADY_O = arready_ff;
  assign RVALID_O = rvalid_ff;
  assign RDATA_O = rdata_ff;
  assign RRESP_O = rresp_ff;
  assign CORE_CLK_O = core_clk_ff;
  assign BUS_CLK_O = bus_clk_ff;
  assign REF_TICK_O = tick_ff;
  assign LED_SLOW_CLK_O = mux_ff[0];
  assign RADIO_SLEEP_CLK_O = mux_ff[1];
  assign POWER_MGMT_CLK_O = mux_ff[2];
  assign SENSOR_CLK_O = mux_ff[3];
  assign PLL_HALF_CLK_O = pll_half;
  assign OSC_DIV256_O = osc_d256;
  assign RADIO_CLK_OK_O = radio_ok_ff;
  assign APLL_PU_O = apll_pu_ff;
  assign APLL_MULT_O = apll_mult_ff;
  assign APLL_ODIV_O = apll_odiv_ff;

endmodule

// File: verif/soc_clock_tree_control_properties.sv
// Port-level assertions for the clock tree control block
`timescale 1ns/1ps
module clk_tree_checker (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic AWREADY_O,
  input wire logic WREADY_O,
  input wire logic BVALID_O,
  input wire logic ARREADY_O,
  input wire logic RVALID_O,
  input wire logic CORE_CLK_O,
  input wire logic BUS_CLK_O,
  input wire logic REF_TICK_O,
  input wire logic PLL_HALF_CLK_O,
  input wire logic [22:0] APLL_MULT_O,
  input wire logic [6:0] APLL_ODIV_O
);
  // ****************************************************************
  // Clock shape, audio PLL term range and bus handshake checks
  // ****************************************************************
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  core_glitch_a: assert property ($rose(CORE_CLK_O) |=> CORE_CLK_O)
    else $error("core clock runt high pulse");
  bus_glitch_a: assert property ($fell(BUS_CLK_O) |=> !BUS_CLK_O)
    else $error("bus clock runt low pulse");
  bus_follow_a: assert property ($changed(BUS_CLK_O) |->
    $past(CORE_CLK_O) != $past(CORE_CLK_O, 2))
    else $error("bus clock moved without a core toggle");
  tick_pulse_a: assert property (REF_TICK_O |=> !REF_TICK_O)
    else $error("reference tick longer than one cycle");
  half_width_a: assert property ($rose(PLL_HALF_CLK_O) |=>
    PLL_HALF_CLK_O[*3])
    else $error("half rate clock high too short");
  odiv_range_a: assert property (NRST_I && $past(NRST_I) |->
    APLL_ODIV_O[0] == 1'b0 && APLL_ODIV_O >= 7'h04 && APLL_ODIV_O <= 7'h42)
    else $error("audio divider term out of range");
  mult_range_a: assert property (NRST_I && $past(NRST_I) |->
    APLL_MULT_O[22:16] >= 7'h04 && APLL_MULT_O[22:16] <= 7'h43)
    else $error("audio multiplier term out of range");
  aw_pair_a: assert property (AWREADY_O == WREADY_O)
    else $error("address and data ready differ");
  b_follow_a: assert property (AWREADY_O |=> BVALID_O && !AWREADY_O)
    else $error("write response late");
  r_follow_a: assert property (ARREADY_O |=> RVALID_O && !ARREADY_O)
    else $error("read data late");
endmodule

// File: verif/soc_clock_tree_control_bench.sv
// Self-checking bench for the clock tree control block
`timescale 1ns/1ps
module soc_clock_tree_control_bench
  import clk_tree_pkg::*;
;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR %0t: got %0h want %0h", $time, a, b); end end
  // ****************************************************************
  // Stimulus, monitors and bus tasks
  // ****************************************************************
  localparam int KK[6] = '{6, 5, 7, 8, 9, 11};
  localparam int W = 3000;
  logic CLK_I, NRST_I, awv, wv, brdy, arv, rrdy, slp, lowp;
  logic [7:0] awa, ara;
  logic [8:0] prv;
  logic [31:0] wd;
  logic [5:0] src;
  wire awr, wrr, bv, arr, rv, rok, pu;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [22:0] mult;
  wire [6:0] odiv;
  wire [8:0] mon;
  int n_errors, n_checks, cyc, ph[6], cnt[9], base[9];

  soc_clock_tree_control i_dut (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .AWADDR_I(awa), .AWVALID_I(awv),
    .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'hF), .WVALID_I(wv),
    .WREADY_O(wrr), .BRESP_O(br), .BVALID_O(bv), .BREADY_I(brdy),
    .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdat),
    .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rrdy), .XTAL_CLK_I(src[0]),
    .PLL_CLK_I(src[1]), .OSC8M_CLK_I(src[2]), .AUDIO_PLL_CLOCK_I(src[3]),
    .OSC150K_CLK_I(src[4]), .XTAL32K_CLK_I(src[5]), .SLEEP_I(slp),
    .LOW_POWER_I(lowp), .CORE_CLK_O(mon[0]), .BUS_CLK_O(mon[1]),
    .REF_TICK_O(mon[2]), .LED_SLOW_CLK_O(mon[3]), .PLL_HALF_CLK_O(mon[4]),
    .OSC_DIV256_O(mon[8]), .RADIO_SLEEP_CLK_O(mon[5]),
    .POWER_MGMT_CLK_O(mon[6]), .SENSOR_CLK_O(mon[7]), .RADIO_CLK_OK_O(rok),
    .APLL_PU_O(pu), .APLL_MULT_O(mult), .APLL_ODIV_O(odiv));

  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end

  // Slow source clocks and rising-edge counters of every clock output
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 6; i++) begin
      ph[i] = (ph[i] + 1) % KK[i];
      if (ph[i] == 0) src[i] <= ~src[i];
    end
    for (int i = 0; i < 9; i++) if (mon[i] && !prv[i]) cnt[i]++;
    prv <= mon;
  end

  always @(posedge CLK_I) if (cyc == 60000) begin
    n_errors++;
    results();
  end

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge CLK_I);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do @(posedge CLK_I); while (awr !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    while (bv !== 1'b1) @(posedge CLK_I);
    `CHK(br, r)
    brdy <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge CLK_I);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do @(posedge CLK_I); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge CLK_I);
    `CHK(rdat, d)
    `CHK(rr, r)
    rrdy <= 1'b0;
  endtask

  // Counts output rising edges over a window against expected periods
  task automatic meas(input int p[8]);
    int e, g;
    repeat (4000) @(posedge CLK_I);
    base = cnt;
    repeat (W) @(posedge CLK_I);
    for (int i = 0; i < 8; i++) begin
      e = p[i] == 0 ? 0 : W / p[i];
      g = cnt[i] - base[i] - e;
      `CHK(g inside {[-1:1]}, 1'b1)
    end
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    int s, per, lp, d, mhz, p[8];
    localparam int RAD[4] = '{2 * KK[4], 2 * KK[5], 2 * KK[2], 2 * KK[0]};
    localparam int PMG[4] = '{2 * KK[4], 2 * KK[5], 512 * KK[2], 2 * KK[4]};
    NRST_I = 1'b0;
    awv = 1'b0;
    wv = 1'b0;
    brdy = 1'b0;
    arv = 1'b0;
    rrdy = 1'b0;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    src = 6'h00;
    slp = 1'b0;
    lowp = 1'b0;
    prv = 9'h000;
    cyc = 0;
    repeat (3) @(posedge CLK_I);
    NRST_I <= 1'b1;
    for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
    rd(8'h28, 32'h0, RESP_SLVERR);
    wr(8'h24, 32'hFF, RESP_SLVERR);
    // Multiplier kept within 350-500 MHz for a 40 MHz crystal
    wr(8'h18, 32'hFFC7FFFF, RESP_OKAY);
    rd(8'h18, 32'h1F07FFFF, RESP_OKAY);
    `CHK(mult, {7'h0B, 16'hFFFF})
    `CHK(odiv, 7'h42)
    wr(8'h18, 32'h00061234, RESP_OKAY);
    repeat (3) @(posedge CLK_I);
    `CHK(mult, {7'h0A, 16'h1234})
    `CHK(odiv, 7'h04)
    for (int i = 0; i < 8; i++) begin
      slp <= i[2];
      wr(8'h1C, 32'(i[1:0]), RESP_OKAY);
      repeat (6) @(posedge CLK_I);
      `CHK(pu, ~i[1] & (i[0] | ~i[2]))
    end
    slp <= 1'b0;
    wr(8'h1C, 32'h0, RESP_OKAY);
    wr(8'h04, 32'h2, RESP_OKAY);
    wr(8'h20, 32'h4, RESP_OKAY);
    for (int i = 0; i < 4; i++) wr(8'(8 + 4 * i), 32'(i + 1), RESP_OKAY);
    for (int k = 0; k < 5; k++) begin
      s = k == 4 ? 1 : k;
      lp = k == 4;
      per = s == 3 || lp;
      lowp <= lp[0];
      wr(8'h00, 32'(s + 4 * per + 264 * (s % 2) + 80 * s), RESP_OKAY);
      d = s % 2 ? (per ? 2 : 4) : 3;
      p[0] = d * 2 * KK[s];
      p[1] = lp ? 0 : s == 1 ? 8 * KK[1] : s == 3 ? 2 * p[0] : p[0];
      p[2] = p[1] * (s == 0 ? 3 : s == 1 ? 2 : s == 2 ? 5 : 4);
      p[3] = s % 2 ? 2 * KK[2] : p[1];
      p[4] = 4 * KK[1];
      p[5] = RAD[s];
      p[6] = PMG[s];
      p[7] = s % 2 ? 2 * KK[2] : 10 * KK[0];
      meas(p);
      mhz = s == 1 ? MAIN_PLL_MHZ / (per ? 2 : 4) : 0;
      `CHK(rok, 1'(s == 1 && !lp))
      rd(8'h24, 32'(s + 4 * per + 8 * !lp + 16 + 32 * (s == 1 && !lp) +
        256 * mhz), RESP_OKAY);
    end
    `CHK((cnt[8] - cyc / (512 * KK[2])) inside {[-1:1]}, 1'b1)
    results();
  end
endmodule

bind soc_clock_tree_control clk_tree_checker i_chk (
  .CLK_I, .NRST_I, .AWREADY_O, .WREADY_O, .BVALID_O, .ARREADY_O,
  .RVALID_O, .CORE_CLK_O, .BUS_CLK_O, .REF_TICK_O, .PLL_HALF_CLK_O,
  .APLL_MULT_O, .APLL_ODIV_O);
